//--- rtl/power_state_status_and_wake_source.sv
// power status and on/wake cause register bank with wishbone slave
// What this block does
// - thermal flag set while temperature above threshold
// - bit 10 shows battery supplying current
// - bit 9 shows wall adaptor present
// - bit 8 shows usb supply present
// - bits 4:0 show main state code
// - active, sleep, shutdown, reset codes reported
// - bit 15 records on versus wake
// - bit 11 records gpio cause
// - bit 10 records low supply wake only
// - bit 8 records charger wake cause
// - bit 7 records watchdog wake cause
// - bit 6 records software wake request
// - bit 5 records alarm cause
// - bit 4 records on pin cause
// - bit 3 records converter undervoltage reset
// - bit 2 records software reset cause
// - bit 1 records hardware reset cause
// - bit 0 records watchdog reset cause
// - state machine clears causes, writes ignored
`timescale 1ns/1ps
`default_nettype none
module power_state_status_and_wake_source (
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // asynchronous status levels from analogue blocks
  input wire logic thermal_warning_flag_i,
  input wire logic battery_supplying_flag_i,
  input wire logic wall_adaptor_present_flag_i,
  input wire logic usb_supply_present_flag_i,
  // from the power state machine, same clock
  input wire logic [4:0] main_state_i,
  input wire logic event_i,
  input wire logic on_vs_wake_flag_i,
  input wire logic [pwr_status_pkg::CAUSE_W-1:0] cause_i,
  // copies of the two registers
  output logic [15:0] system_condition_status_o,
  output logic [15:0] power_on_cause_record_o
);

  // ==========================================================
  // synchronised status levels
  logic thw_s;
  logic batt_s;
  logic wall_s;
  logic usb_s;
  logic [4:0] state_rep;

  level_sync u_sync_thw (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(thermal_warning_flag_i),
    .q_o(thw_s)
  );
  level_sync u_sync_batt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(battery_supplying_flag_i),
    .q_o(batt_s)
  );
  level_sync u_sync_wall (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(wall_adaptor_present_flag_i),
    .q_o(wall_s)
  );
  level_sync u_sync_usb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(usb_supply_present_flag_i),
    .q_o(usb_s)
  );

  // unlisted state codes are reported as zero
  state_code_filter u_state_filter (
    .code_i(main_state_i),
    .code_o(state_rep)
  );

  // ==========================================================
  // system status register
  logic [15:0] status_ff;
  logic [15:0] nxt_status;

  // live levels, reserved bits zero
  always_comb begin
    nxt_status = pwr_status_pkg::REG_RESET;
    nxt_status[pwr_status_pkg::THW_BIT] = thw_s;
    nxt_status[pwr_status_pkg::BATT_BIT] = batt_s;
    nxt_status[pwr_status_pkg::WALL_BIT] = wall_s;
    nxt_status[pwr_status_pkg::USB_BIT] = usb_s;
    nxt_status[pwr_status_pkg::STATE_MSB:0] = state_rep;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_ff <= pwr_status_pkg::REG_RESET;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // ==========================================================
  // on/wake cause record
  logic [15:0] cause_ff;
  logic [15:0] nxt_cause;

  // each event replaces the whole record, so only the latest causes remain
  always_comb begin
    nxt_cause = pwr_status_pkg::REG_RESET;
    nxt_cause[pwr_status_pkg::ON_VS_WAKE_BIT] = on_vs_wake_flag_i;
    nxt_cause[pwr_status_pkg::GPIO_BIT] = cause_i[pwr_status_pkg::C_GPIO];
    // low supply may only wake, never a full on
    nxt_cause[pwr_status_pkg::LOW_SUPPLY_BIT] = cause_i[pwr_status_pkg::C_LOW_SUPPLY] & ~on_vs_wake_flag_i;
    nxt_cause[pwr_status_pkg::CHG_BIT] = cause_i[pwr_status_pkg::C_CHG];
    nxt_cause[pwr_status_pkg::WDOG_WAKE_BIT] = cause_i[pwr_status_pkg::C_WDOG];
    // state machine flags the wake that followed the host clearing sleep
    nxt_cause[pwr_status_pkg::SW_WAKE_BIT] = cause_i[pwr_status_pkg::C_SW_WAKE];
    nxt_cause[pwr_status_pkg::RTC_BIT] = cause_i[pwr_status_pkg::C_RTC];
    nxt_cause[pwr_status_pkg::ON_PIN_BIT] = cause_i[pwr_status_pkg::C_ON_PIN];
    nxt_cause[pwr_status_pkg::CNV_UV_BIT] = cause_i[pwr_status_pkg::C_CNV_UV];
    nxt_cause[pwr_status_pkg::RST_SW_BIT] = cause_i[pwr_status_pkg::C_RST_SW];
    nxt_cause[pwr_status_pkg::RST_HW_BIT] = cause_i[pwr_status_pkg::C_RST_HW];
    nxt_cause[pwr_status_pkg::RST_WDOG_BIT] = cause_i[pwr_status_pkg::C_RST_WDOG];
  end

  // updated only by the state machine event, bus writes never touch it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_ff <= pwr_status_pkg::REG_RESET;
    end else if (event_i) begin
      cause_ff <= nxt_cause;
    end
  end

  // ==========================================================
  // wishbone slave, registered ack gives one wait state, ack drops after one cycle
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;
  logic req;

  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;

  // read mux; writes are accepted and discarded
  always_comb begin
    case (wb_adr_i)
      pwr_status_pkg::SYS_STATUS_ADDR: nxt_dat = {16'h0000, status_ff};
      pwr_status_pkg::ON_CAUSE_ADDR: nxt_dat = {16'h0000, cause_ff};
      default: nxt_dat = pwr_status_pkg::UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= pwr_status_pkg::UNMAPPED_DATA;
    end else if (req) begin
      dat_ff <= wb_we_i ? pwr_status_pkg::UNMAPPED_DATA : nxt_dat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign system_condition_status_o = status_ff;
  assign power_on_cause_record_o = cause_ff;

endmodule : power_state_status_and_wake_source
`default_nettype wire

//--- rtl/pwr_status_pkg.sv
// constants for the power status and wake source register bank
package pwr_status_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [15:0] SYS_STATUS_IDX = 16'h400D;
  localparam logic [15:0] ON_CAUSE_IDX = 16'h400E;
  localparam int ADDR_W = 18;
  localparam logic [17:0] SYS_STATUS_ADDR = {SYS_STATUS_IDX, 2'b00};
  localparam logic [17:0] ON_CAUSE_ADDR = {ON_CAUSE_IDX, 2'b00};
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  // system status fields
  localparam int THW_BIT = 15;
  localparam int BATT_BIT = 10;
  localparam int WALL_BIT = 9;
  localparam int USB_BIT = 8;
  localparam int STATE_MSB = 4;
  // on-cause fields
  localparam int ON_VS_WAKE_BIT = 15;
  localparam int GPIO_BIT = 11;
  localparam int LOW_SUPPLY_BIT = 10;
  localparam int CHG_BIT = 8;
  localparam int WDOG_WAKE_BIT = 7;
  localparam int SW_WAKE_BIT = 6;
  localparam int RTC_BIT = 5;
  localparam int ON_PIN_BIT = 4;
  localparam int CNV_UV_BIT = 3;
  localparam int RST_SW_BIT = 2;
  localparam int RST_HW_BIT = 1;
  localparam int RST_WDOG_BIT = 0;
  // cause input vector layout (index into cause_i)
  localparam int C_GPIO = 0;
  localparam int C_LOW_SUPPLY = 1;
  localparam int C_CHG = 2;
  localparam int C_WDOG = 3;
  localparam int C_RTC = 4;
  localparam int C_ON_PIN = 5;
  localparam int C_CNV_UV = 6;
  localparam int C_RST_SW = 7;
  localparam int C_RST_HW = 8;
  localparam int C_RST_WDOG = 9;
  // host cleared the chip sleep control
  localparam int C_SW_WAKE = 10;
  localparam int CAUSE_W = 11;
  // main state codes
  localparam logic [4:0] ST_OFF = 5'h00;
  localparam logic [4:0] ST_ON_CHECK = 5'h01;
  localparam logic [4:0] ST_OTP_LOAD_DONE = 5'h02;
  localparam logic [4:0] ST_OTP_READ = 5'h03;
  localparam logic [4:0] ST_EXT_CFG_LOAD = 5'h04;
  localparam logic [4:0] ST_EXT_CFG_DONE = 5'h05;
  localparam logic [4:0] ST_BANDGAP_SETTLE = 5'h06;
  localparam logic [4:0] ST_OTP_PROGRAM_START = 5'h09;
  localparam logic [4:0] ST_FIRST_POWER_DOWN = 5'h0A;
  localparam logic [4:0] ST_PROGRAM = 5'h0B;
  localparam logic [4:0] ST_PROGRAM_DONE = 5'h0C;
  localparam logic [4:0] ST_OTP_WRITE = 5'h0D;
  localparam logic [4:0] ST_OTP_VERIFY = 5'h0E;
  localparam logic [4:0] ST_VERIFY_DONE = 5'h0F;
  localparam logic [4:0] ST_SHUTDOWN_OTP_RELOAD = 5'h10;
  localparam logic [4:0] ST_SHUTDOWN = 5'h13;
  localparam logic [4:0] ST_SECOND_POWER_DOWN = 5'h18;
  localparam logic [4:0] ST_RESET = 5'h1A;
  localparam logic [4:0] ST_SLEEP = 5'h1C;
  localparam logic [4:0] ST_SLEEP_DELAY = 5'h1D;
  localparam logic [4:0] ST_RESET_CHECK = 5'h1E;
  localparam logic [4:0] ST_ACTIVE = 5'h1F;
endpackage : pwr_status_pkg

//--- rtl/level_sync.sv
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module level_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_ff;
  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_ff <= d_i;
      q_o <= meta_ff;
    end
  end
endmodule : level_sync
`default_nettype wire

//--- rtl/state_code_filter.sv
// maps a raw main state code to a reported code, unlisted codes read zero
`timescale 1ns/1ps
`default_nettype none
module state_code_filter (
  input wire logic [4:0] code_i,
  output logic [4:0] code_o
);
  // only listed codes pass through
  always_comb begin
    case (code_i)
      pwr_status_pkg::ST_OFF,
      pwr_status_pkg::ST_ON_CHECK,
      pwr_status_pkg::ST_OTP_LOAD_DONE,
      pwr_status_pkg::ST_OTP_READ,
      pwr_status_pkg::ST_EXT_CFG_LOAD,
      pwr_status_pkg::ST_EXT_CFG_DONE,
      pwr_status_pkg::ST_BANDGAP_SETTLE,
      pwr_status_pkg::ST_OTP_PROGRAM_START,
      pwr_status_pkg::ST_FIRST_POWER_DOWN,
      pwr_status_pkg::ST_PROGRAM,
      pwr_status_pkg::ST_PROGRAM_DONE,
      pwr_status_pkg::ST_OTP_WRITE,
      pwr_status_pkg::ST_OTP_VERIFY,
      pwr_status_pkg::ST_VERIFY_DONE,
      pwr_status_pkg::ST_SHUTDOWN_OTP_RELOAD,
      pwr_status_pkg::ST_SHUTDOWN,
      pwr_status_pkg::ST_SECOND_POWER_DOWN,
      pwr_status_pkg::ST_RESET,
      pwr_status_pkg::ST_SLEEP,
      pwr_status_pkg::ST_SLEEP_DELAY,
      pwr_status_pkg::ST_RESET_CHECK,
      pwr_status_pkg::ST_ACTIVE: code_o = code_i;
      default: code_o = pwr_status_pkg::ST_OFF;
    endcase
  end
endmodule : state_code_filter
`default_nettype wire

//--- verif/pwr_status_checker.sv
// concurrent checks on the power status register bank ports
`timescale 1ns/1ps
`default_nettype none
module pwr_status_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic thermal_warning_flag_i,
  input wire logic event_i,
  input wire logic [15:0] system_condition_status_o,
  input wire logic [15:0] power_on_cause_record_o
);
  // ==========
  // bus and field checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence quiet3;
    !event_i [*3];
  endsequence
  sequence rd_at(a);
    wb_ack_o && !wb_we_i && wb_adr_i == a;
  endsequence
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held past one cycle");
  AST_ACK_IN_CYCLE: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i) else $error("ack outside a cycle");
  AST_STATUS_RSVD: assert property ((system_condition_status_o & 16'h78E0) == 16'h0000)
    else $error("status reserved bit set");
  AST_CAUSE_RSVD: assert property ((power_on_cause_record_o & 16'h7200) == 16'h0000)
    else $error("cause reserved bit set");
  AST_SYSTEM_SUPPLY_LOW_THRESHOLD_WAKE: assert property (power_on_cause_record_o[10] |-> !power_on_cause_record_o[15])
    else $error("low supply cause on full on");
  // read data is captured one edge before ack, so compare with the value held then
  AST_READ_STATUS: assert property (rd_at(pwr_status_pkg::SYS_STATUS_ADDR) |->
    wb_dat_o == {16'h0000, $past(system_condition_status_o)}) else $error("status read data wrong");
  AST_READ_CAUSE: assert property (rd_at(pwr_status_pkg::ON_CAUSE_ADDR) |->
    wb_dat_o == {16'h0000, $past(power_on_cause_record_o)}) else $error("cause read data wrong");
  AST_READ_UNMAPPED: assert property (wb_ack_o && !wb_we_i && wb_adr_i != pwr_status_pkg::SYS_STATUS_ADDR &&
    wb_adr_i != pwr_status_pkg::ON_CAUSE_ADDR |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  AST_CAUSE_HOLD: assert property (quiet3 |=> $stable(power_on_cause_record_o))
    else $error("cause changed without event");
  AST_THERMAL: assert property (thermal_warning_flag_i [*5] |-> system_condition_status_o[15])
    else $error("thermal flag not shown");
endmodule : pwr_status_checker
`default_nettype wire

//--- verif/wb_host_model.sv
// classic wishbone host model, one transfer per request
`timescale 1ns/1ps
`default_nettype none
module wb_host_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic we_i,
  input wire logic [17:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_i,
  input wire logic [31:0] rd_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [17:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o,
  output logic [31:0] rd_o,
  output logic done_o
);
  // ==========
  // request held until ack; done blocks a restart so cyc idles at least two cycles
  assign sel_o = 4'hF;
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
    end else if (cyc_o && ack_i) begin
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      done_o <= 1'b1;
      rd_o <= rd_i;
      dat_o <= ~dat_o; // released data must not look valid
    end else if (go_i && !cyc_o && !done_o) begin
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= we_i;
      adr_o <= adr_i;
      dat_o <= dat_i;
    end
  end
endmodule : wb_host_model
`default_nettype wire

//--- verif/test_power_state_status_and_wake_source.sv
// testbench for the power status and wake cause register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module test_power_state_status_and_wake_source;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic go = 1'b0, we = 1'b0, ev = 1'b0, onf = 1'b0, done, cyc, stb, wwe, ack;
  logic [17:0] adr = '0, wadr;
  logic [31:0] wdat = '0, mdat, rdat, dout;
  logic [3:0] sel, flags = '0;
  logic [4:0] st = '0;
  logic [10:0] cause = '0;
  logic [15:0] sreg, creg;
  int n_mismatch = 0, checks_done = 0, cyc_n = 0;
  int fpos[4] = '{8, 9, 10, 15};
  int cpos[11] = '{11, 10, 8, 7, 5, 4, 3, 2, 1, 0, 6};
  power_state_status_and_wake_source dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(wwe), .wb_adr_i(wadr), .wb_sel_i(sel), .wb_dat_i(mdat), .wb_dat_o(dout), .wb_ack_o(ack),
    .thermal_warning_flag_i(flags[3]), .battery_supplying_flag_i(flags[2]), .wall_adaptor_present_flag_i(flags[1]),
    .usb_supply_present_flag_i(flags[0]), .main_state_i(st), .event_i(ev), .on_vs_wake_flag_i(onf),
    .cause_i(cause), .system_condition_status_o(sreg), .power_on_cause_record_o(creg));
  wb_host_model host_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .we_i(we), .adr_i(adr), .dat_i(wdat),
    .ack_i(ack), .rd_i(dout), .cyc_o(cyc), .stb_o(stb), .we_o(wwe), .adr_o(wadr), .sel_o(sel), .dat_o(mdat),
    .rd_o(rdat), .done_o(done));
  // ==========
  // clock, bus tasks and stimulus helpers
  initial forever #4 clk_i = ~clk_i;
  task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge clk_i);
    go <= 1'b1; we <= w; adr <= a; wdat <= d;
    @(posedge clk_i);
    go <= 1'b0;
    wait (done === 1'b1);
    @(posedge clk_i);
  endtask : xfer
  task automatic rd(input logic [17:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK(rdat, e)
  endtask : rd
  // levels cross a synchroniser, so give them time before reading
  task automatic settle;
    repeat (8) @(posedge clk_i);
  endtask : settle
  task automatic fire(input logic on, input logic [10:0] c);
    @(posedge clk_i);
    ev <= 1'b1; onf <= on; cause <= c;
    @(posedge clk_i);
    ev <= 1'b0; cause <= '0;
    settle;
  endtask : fire
  function automatic logic [31:0] shown(input int c);
    return ((c <= 6) || (c >= 9 && c <= 16) || c == 19 || c == 24 || c == 26 || c >= 28) ? 32'(c) : 32'h0;
  endfunction : shown
  task automatic complete_run;
    $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // ==========
  // hang guard
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 6000) begin n_mismatch++; complete_run; end
  end
  // ==========
  // test sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(pwr_status_pkg::SYS_STATUS_ADDR, 32'h0);
    rd(pwr_status_pkg::ON_CAUSE_ADDR, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      flags <= 4'(1 << i);
      settle;
      rd(pwr_status_pkg::SYS_STATUS_ADDR, 32'h1 << fpos[i]);
    end
    flags <= 4'hF;
    settle;
    rd(pwr_status_pkg::SYS_STATUS_ADDR, 32'h8700);
    flags <= 4'h0;
    $display("test flags done");
    for (int c = 0; c < 32; c++) begin
      st <= 5'(c);
      settle;
      rd(pwr_status_pkg::SYS_STATUS_ADDR, shown(c));
    end
    $display("test states done");
    // each event must wipe the causes of the one before
    // index 10 is the wake after the host cleared the chip sleep control
    for (int i = 0; i < 11; i++) begin
      fire(i != 1 && i != 10, 11'h1 << i);
      rd(pwr_status_pkg::ON_CAUSE_ADDR, ((i != 1 && i != 10) ? 32'h8000 : 32'h0) | (32'h1 << cpos[i]));
    end
    fire(1'b1, 11'h002);
    rd(pwr_status_pkg::ON_CAUSE_ADDR, 32'h8000);
    $display("test causes done");
    xfer(1'b1, pwr_status_pkg::ON_CAUSE_ADDR, 32'hFFFF);
    rd(pwr_status_pkg::ON_CAUSE_ADDR, 32'h8000);
    xfer(1'b1, pwr_status_pkg::SYS_STATUS_ADDR, 32'hFFFF);
    // state input was left at the active code by the state sweep
    rd(pwr_status_pkg::SYS_STATUS_ADDR, 32'(pwr_status_pkg::ST_ACTIVE));
    rd(18'h00010, pwr_status_pkg::UNMAPPED_DATA);
    $display("test writes done");
    complete_run;
  end
endmodule : test_power_state_status_and_wake_source
bind power_state_status_and_wake_source pwr_status_checker chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .thermal_warning_flag_i(thermal_warning_flag_i), .event_i(event_i),
  .system_condition_status_o(system_condition_status_o), .power_on_cause_record_o(power_on_cause_record_o));
`default_nettype wire
